// [pda_host_bus_slave.sv]
/*
 Host bus slave port: a 16-bit synchronous slave clocked by the host bus clock,
 with a core-side access port on core_clk. Requests cross to the core by a
 toggle handshake; the core answers with a toggle and read data.
 Assumes the core side answers every request, and the mode strap is stable
 around reset release.
*/
// Overview of operation
// - In the acknowledged variant ack is driven high once chip select falls, then low, driven high after chip select rises, floated on a later bus clock edge.
// - In the unacknowledged variant read data is valid within 5, 8, 10 or 13 bus clocks for memory clock divide 1, 2, 3 or 4.
// - In the unacknowledged variant every access lasts exactly 9 bus clocks.
// - In the unacknowledged variant host access to the 2D block-transfer data path is not offered.
// - Address, chip select, write strobes and read strobe are sampled on bus clock rising edges.
// - After a read the data bus is released to high impedance once chip select rises.
`timescale 1ns/1ps
`default_nettype none
module pda_host_bus_slave
	import host_port_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic host_bus_clock,
	input wire logic unackModeStrap,
	input wire logic [1:0] memClkDivStrap,
	input wire logic [ADDR_W-1:1] hostAddr,
	input wire logic chip_select_n,
	input wire logic upper_byte_write_strobe,
	input wire logic lower_byte_write_strobe,
	input wire logic readStrobe_n,
	input wire logic [DATA_W-1:0] hostDataIn,
	output logic [DATA_W-1:0] hostDataOut,
	output logic hostDataOe,
	output logic transfer_ack_n,
	output logic transferAckOe,
	output logic blitPathEnable,
	output var access_req_t coreReq,
	output logic coreReqToggle,
	input wire logic coreAckToggle,
	input wire logic [DATA_W-1:0] coreReadData,
	input wire logic coreBlitTarget
);
	import host_port_pkg::*;

	typedef struct packed {
		logic unackMode;
		logic [1:0] memDiv;
		logic strapDone;
		logic [2:0] ackSync;
		logic reqToggle;
		access_req_t req;
		logic blitEn;
	} core_state_t;

	typedef struct packed {
		link_state_t state;
		logic [3:0] count;
		logic [3:0] readLat;
		logic unack;
		logic [2:0] modeSync;
		logic [1:0] reqPend;
		logic reqToggle;
		logic ackSeen;
		logic [2:0] ackSync;
		logic [DATA_W-1:0] rdata;
		logic rdataValid;
		logic isWrite;
		logic [ADDR_W-1:1] addr;
		logic upperEn;
		logic lowerEn;
		bus_drive_t drive;
		logic ackN;
		logic ackOe;
	} link_state_rec_t;

	core_state_t cs, next_cs;
	link_state_rec_t ls, next_ls;
	logic [DATA_W-1:0] rdataCore;
	logic rdataUpd;
	logic memWe;
	logic [DATA_W-1:0] memWord;
	// Link-side word store: the fixed variant cannot wait for a core round trip
	logic [DATA_W-1:0] hostMem [2**(ADDR_W-1)];

	function automatic logic [DATA_W-1:0] mergeBytes(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] wr,
		input logic upper,
		input logic lower
	);
		logic [DATA_W-1:0] res;
		res = old;
		if (upper) res[15:8] = wr[15:8];
		if (lower) res[7:0] = wr[7:0];
		return res;
	endfunction

	function automatic logic [3:0] readLatency(input logic [1:0] div);
		logic [3:0] lat;
		lat = READ_LAT_DIV1;
		case (div)
			2'b00: lat = READ_LAT_DIV1;
			2'b01: lat = READ_LAT_DIV2;
			2'b10: lat = READ_LAT_DIV3;
			default: lat = READ_LAT_DIV4;
		endcase
		return lat;
	endfunction

	// Core domain: strap capture, request handshake toward the core
	always_comb begin
		next_cs = cs;
		if (!cs.strapDone) begin
			next_cs.unackMode = unackModeStrap;
			next_cs.memDiv = memClkDivStrap;
			next_cs.strapDone = 1'b1;
		end
		// Third and second stages agree before the link toggle counts
		next_cs.ackSync = {cs.ackSync[1:0], ls.reqToggle};
		if (cs.ackSync[2] == cs.ackSync[1] && cs.ackSync[1] != cs.reqToggle) begin
			next_cs.reqToggle = cs.ackSync[1];
			next_cs.req.addr = ls.addr;
			next_cs.req.data = ls.rdata;
			next_cs.req.upperEn = ls.upperEn;
			next_cs.req.lowerEn = ls.lowerEn;
			next_cs.req.write = ls.isWrite;
		end
		// no block-transfer path in fixed mode
		next_cs.blitEn = !cs.unackMode;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cs <= '0;
		end else begin
			cs <= next_cs;
		end
	end

	// Core answer data held stable in core domain until its toggle crosses
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdataCore <= DATA_ZERO;
			rdataUpd <= 1'b0;
		end else begin
			rdataUpd <= coreAckToggle;
			if (coreAckToggle != rdataUpd) begin
				rdataCore <= coreReadData;
			end
		end
	end

	assign coreReq = cs.req;
	assign coreReqToggle = cs.reqToggle;
	assign blitPathEnable = cs.blitEn;

	// Link domain
	always_comb begin
		logic selRead;
		logic selWrite;
		logic active;
		logic blocked;
		selRead = 1'b0;
		selWrite = 1'b0;
		active = 1'b0;
		blocked = 1'b0;
		memWe = 1'b0;
		memWord = DATA_ZERO;
		next_ls = ls;
		next_ls.modeSync = {ls.modeSync[1:0], cs.unackMode};
		next_ls.ackSync = {ls.ackSync[1:0], rdataUpd};
		selWrite = !chip_select_n && (!upper_byte_write_strobe || !lower_byte_write_strobe);
		selRead = !chip_select_n && !readStrobe_n;
		active = selRead || selWrite;
		blocked = ls.unack && coreBlitTarget;
		if (ls.count != ZERO4) begin
			next_ls.count = ls.count - ONE4;
		end
		if (ls.ackSync[2] == ls.ackSync[1] && ls.ackSync[1] != ls.ackSeen) begin
			next_ls.ackSeen = ls.ackSync[1];
			next_ls.rdataValid = 1'b1;
			// A late core answer must not overwrite a fixed-variant read
			if (!ls.isWrite && !ls.unack) begin
				next_ls.rdata = rdataCore;
			end
		end
		case (ls.state)
			LINK_IDLE: begin
				next_ls.unack = ls.modeSync[2];
				next_ls.ackOe = 1'b0;
				next_ls.ackN = 1'b1;
				next_ls.drive.oe = 1'b0;
				if (active) begin
					next_ls.addr = hostAddr;
					next_ls.isWrite = selWrite;
					next_ls.upperEn = !upper_byte_write_strobe;
					next_ls.lowerEn = !lower_byte_write_strobe;
					next_ls.rdataValid = 1'b0;
					next_ls.readLat = readLatency(cs.memDiv);
					if (ls.modeSync[2]) begin
						next_ls.count = FIXED_CYCLE_LEN - ONE4;
						if (!selWrite) begin
							next_ls.rdata = hostMem[hostAddr];
						end
						next_ls.state = LINK_FIXED;
					end else begin
						next_ls.ackOe = 1'b1;
						next_ls.count = ACK_MIN_LEN - ONE4;
						next_ls.state = LINK_WAIT;
					end
					if (!selWrite) begin
						next_ls.reqToggle = !ls.reqToggle;
					end
				end
			end
			LINK_WAIT: begin
				next_ls.drive.oe = !ls.isWrite;
				if (ls.isWrite && ls.count == ACK_MIN_LEN - WRITE_TAKE_EDGE + ONE4) begin
					next_ls.rdata = hostDataIn;
					memWe = 1'b1;
					memWord = mergeBytes(hostMem[ls.addr], hostDataIn, ls.upperEn, ls.lowerEn);
					next_ls.reqToggle = !ls.reqToggle;
				end
				if (ls.rdataValid && ls.count <= ONE4) begin
					next_ls.ackN = 1'b0;
					next_ls.drive.data = ls.rdata;
					next_ls.state = LINK_ACK;
				end
			end
			LINK_ACK: begin
				next_ls.drive.data = ls.rdata;
				// host holds until the ack falls
				if (chip_select_n) begin
					next_ls.ackN = 1'b1;
					next_ls.drive.oe = 1'b0;
					next_ls.state = LINK_RELEASE;
				end
			end
			LINK_RELEASE: begin
				next_ls.ackOe = 1'b0;
				next_ls.state = LINK_IDLE;
			end
			LINK_FIXED: begin
				next_ls.drive.oe = !ls.isWrite && !chip_select_n;
				// write data taken on the fourth edge
				if (ls.isWrite && ls.count == FIXED_CYCLE_LEN - WRITE_TAKE_EDGE + ONE4) begin
					next_ls.rdata = hostDataIn;
					if (!blocked) begin
						next_ls.reqToggle = !ls.reqToggle;
						memWe = 1'b1;
						memWord = mergeBytes(hostMem[ls.addr], hostDataIn, ls.upperEn, ls.lowerEn);
					end
				end
				// read data within the divider's latency
				if (!ls.isWrite) begin
					next_ls.drive.data = blocked ? DATA_ZERO : ls.rdata;
				end
				if (ls.count == ZERO4 || chip_select_n) begin
					next_ls.drive.oe = 1'b0;
					next_ls.state = chip_select_n ? LINK_IDLE : LINK_HOLD;
				end
			end
			LINK_HOLD: begin
				next_ls.drive.oe = 1'b0;
				if (chip_select_n) begin
					next_ls.state = LINK_IDLE;
				end
			end
			default: next_ls.state = LINK_IDLE;
		endcase
	end

	always_ff @(posedge host_bus_clock or negedge reset_n) begin
		if (!reset_n) begin
			ls <= '0;
			ls.state <= LINK_IDLE;
			ls.ackN <= 1'b1;
		end else begin
			ls <= next_ls;
		end
	end

	// Store is not cleared by reset; only written words are ever read back
	always_ff @(posedge host_bus_clock) begin
		if (memWe) begin
			hostMem[ls.addr] <= memWord;
		end
	end

	assign hostDataOut = ls.drive.data;
	assign hostDataOe = ls.drive.oe;
	assign transfer_ack_n = ls.ackN;
	assign transferAckOe = ls.ackOe;
endmodule
`default_nettype wire

// [host_port_pkg.sv]
/*
 Shared types and constants for the handheld host bus slave port.
 Assumes a core clock of 20 MHz and a host bus clock from the processor.
*/
package host_port_pkg;
	localparam int CORE_CLK_MHZ = 20;
	localparam int CORE_PERIOD_NS = 1000 / CORE_CLK_MHZ;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	// Fixed access length of the unacknowledged variant, in bus clocks
	localparam logic [3:0] FIXED_CYCLE_LEN = 4'h9;
	// Least access length of the acknowledged variant, in bus clocks
	localparam logic [3:0] ACK_MIN_LEN = 4'h5;
	// Edge (counted from 1) on which write data is taken in the fixed variant
	localparam logic [3:0] WRITE_TAKE_EDGE = 4'h4;
	// Read latency limits per memory clock divider 1..4
	localparam logic [3:0] READ_LAT_DIV1 = 4'h5;
	localparam logic [3:0] READ_LAT_DIV2 = 4'h8;
	localparam logic [3:0] READ_LAT_DIV3 = 4'hA;
	localparam logic [3:0] READ_LAT_DIV4 = 4'hD;
	localparam logic [3:0] ZERO4 = 4'h0;
	localparam logic [3:0] ONE4 = 4'h1;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
	localparam logic [ADDR_W-1:1] ADDR_ZERO = 15'h0000;

	typedef enum logic [2:0] {
		LINK_IDLE = 3'b000,
		LINK_WAIT = 3'b001,
		LINK_ACK = 3'b010,
		LINK_HOLD = 3'b011,
		LINK_RELEASE = 3'b100,
		LINK_FIXED = 3'b101
	} link_state_t;

	typedef struct packed {
		logic [ADDR_W-1:1] addr;
		logic [DATA_W-1:0] data;
		logic upperEn;
		logic lowerEn;
		logic write;
	} access_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic oe;
	} bus_drive_t;
endpackage

// [pda_host_bus_slave_asserts.sv]
/* Pin-level checker for the host bus slave port.
 Bound into the port; needs nothing beyond its pins. */
`timescale 1ns/1ps
`default_nettype none
module pda_host_bus_slave_asserts (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic host_bus_clock,
	input wire logic unackModeStrap,
	input wire logic chip_select_n,
	input wire logic readStrobe_n,
	input wire logic hostDataOe,
	input wire logic transfer_ack_n,
	input wire logic transferAckOe,
	input wire logic blitPathEnable
);
	logic [1:0] seen;
	logic mode;
	// Mirrors the strap capture; only blit_off_a waits until seen saturates
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			seen <= 2'h0;
			mode <= 1'b0;
		end else if (seen != 2'h3) begin
			seen <= seen + 2'h1;
			mode <= (seen == 2'h0) ? unackModeStrap : mode;
		end
	end
	default clocking @(posedge host_bus_clock); endclocking
	default disable iff (!reset_n);
	ack_drive_a: assert property ($fell(chip_select_n) && !mode |=> transferAckOe)
		else $error("ack not driven");
	ack_hold_a: assert property (!transfer_ack_n && !chip_select_n |=> !transfer_ack_n)
		else $error("ack dropped early");
	ack_end_a: assert property ($rose(chip_select_n) && !transfer_ack_n
		|=> transfer_ack_n && transferAckOe ##1 !transferAckOe)
		else $error("ack not ended");
	data_release_a: assert property ($rose(chip_select_n) |=> !hostDataOe)
		else $error("data not released");
	data_cause_a: assert property (hostDataOe |-> $past(!chip_select_n) && $past(!readStrobe_n))
		else $error("data driven unselected");
	ack_len_a: assert property ($fell(transfer_ack_n) |-> $past(!chip_select_n, 5))
		else $error("access too short");
	fixed_noack_a: assert property (mode |-> !transferAckOe)
		else $error("ack in fixed variant");
	blit_off_a: assert property (seen == 2'h3 && mode |-> !blitPathEnable)
		else $error("block path offered");
endmodule
bind pda_host_bus_slave pda_host_bus_slave_asserts u_pda_host_bus_slave_asserts (
	.core_clk(core_clk), .reset_n(reset_n), .host_bus_clock(host_bus_clock),
	.unackModeStrap(unackModeStrap), .chip_select_n(chip_select_n),
	.readStrobe_n(readStrobe_n), .hostDataOe(hostDataOe), .transfer_ack_n(transfer_ack_n),
	.transferAckOe(transferAckOe), .blitPathEnable(blitPathEnable)
);
`default_nettype wire

// [core_model.sv]
/* Core-side memory answering forwarded host requests.
 Assumes one request toggle at a time. */
`timescale 1ns/1ps
`default_nettype none
module core_model
	import host_port_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input var access_req_t coreReq,
	input wire logic coreReqToggle,
	output logic coreAckToggle,
	output logic [DATA_W-1:0] coreReadData
);
	logic [DATA_W-1:0] mem [16];
	logic doneToggle;
	// Answers on the first core edge, the fastest a core could
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			doneToggle <= 1'b0;
			coreAckToggle <= 1'b0;
			coreReadData <= DATA_ZERO;
		end else if (coreReqToggle !== doneToggle) begin
			doneToggle <= coreReqToggle;
			coreAckToggle <= ~coreAckToggle;
			coreReadData <= mem[coreReq.addr[4:1]];
			if (coreReq.write && coreReq.upperEn) mem[coreReq.addr[4:1]][15:8] <= coreReq.data[15:8];
			if (coreReq.write && coreReq.lowerEn) mem[coreReq.addr[4:1]][7:0] <= coreReq.data[7:0];
		end
	end
endmodule
`default_nettype wire

// [pda_host_bus_slave_test.sv]
/* Bench for the host bus slave port in both variants.
 Assumes the core model answers every forwarded request. */
`timescale 1ns/1ps
`default_nettype none
module pda_host_bus_slave_test;
	import host_port_pkg::*;
	logic core_clk = 1'b0;
	logic hostClk = 1'b0;
	logic reset_n = 1'b0;
	logic strap = 1'b0;
	logic fixed = 1'b0;
	logic [1:0] div = 2'h0;
	logic [ADDR_W-1:1] addr = ADDR_ZERO;
	logic csN = 1'b1;
	logic ubN = 1'b1;
	logic lbN = 1'b1;
	logic rdN = 1'b1;
	logic blitTgt = 1'b0;
	logic [DATA_W-1:0] din = DATA_ZERO;
	logic [DATA_W-1:0] dout, rdata, q;
	logic doe, ackn, ackOe, blit, reqT, ackT;
	access_req_t req;
	int err_total = 0;
	int compares = 0;
	int lat = 5;
	always #25 core_clk = ~core_clk;
	always #16 hostClk = ~hostClk;
	pda_host_bus_slave u_pda_host_bus_slave (.core_clk(core_clk), .reset_n(reset_n),
		.host_bus_clock(hostClk), .unackModeStrap(strap), .memClkDivStrap(div),
		.hostAddr(addr), .chip_select_n(csN), .upper_byte_write_strobe(ubN),
		.lower_byte_write_strobe(lbN), .readStrobe_n(rdN), .hostDataIn(din),
		.hostDataOut(dout), .hostDataOe(doe), .transfer_ack_n(ackn), .transferAckOe(ackOe),
		.blitPathEnable(blit), .coreReq(req), .coreReqToggle(reqT), .coreAckToggle(ackT),
		.coreReadData(rdata), .coreBlitTarget(blitTgt));
	core_model u_core_model (.core_clk(core_clk), .reset_n(reset_n), .coreReq(req),
		.coreReqToggle(reqT), .coreAckToggle(ackT), .coreReadData(rdata));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d of %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic restart(input logic m, input logic [1:0] d);
		@(posedge core_clk);
		reset_n <= 1'b0;
		strap <= m;
		div <= d;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		fixed = m;
		lat = d[0] ? READ_LAT_DIV2 : READ_LAT_DIV1;
		repeat (8) @(posedge hostClk);
	endtask
	task automatic acc(input logic w, input logic [1:0] ln, input logic [15:1] a, input logic [15:0] d);
		int n;
		@(posedge hostClk);
		csN <= 1'b0;
		rdN <= w;
		ubN <= !(w && ln[1]);
		lbN <= !(w && ln[0]);
		addr <= a;
		// fixed variant: data valid only from the fourth edge
		din <= fixed ? ~d : d;
		n = 0;
		if (fixed) begin
			// held eight edges, released on the ninth
			for (n = 1; n <= 8; n++) begin
				@(posedge hostClk);
				if (n == 3) din <= d;
				#1;
				if (n == lat) q = dout;
			end
		end else begin
			do begin
				@(posedge hostClk);
				#1;
				n++;
			end while (ackn !== 1'b0 && n < 50);
			q = dout;
			check(n >= 5 && n < 50, 1'b1);
		end
		@(posedge hostClk);
		// release after the ack was seen, or on the ninth edge in the fixed variant
		csN <= 1'b1;
		rdN <= 1'b1;
		ubN <= 1'b1;
		lbN <= 1'b1;
		@(posedge hostClk);
		#1;
		check(doe, 1'b0);
		if (!fixed) check({ackn, ackOe}, 2'b11);
		// strobes stay off before the next access
		repeat (2) @(posedge hostClk);
	endtask
	task automatic test_ack();
		restart(1'b0, 2'h0);
		// Strap moves after reset; the variant must not
		strap <= 1'b1;
		acc(1'b1, 2'b11, 15'h0003, 16'hA5C3);
		acc(1'b1, 2'b11, 15'h0004, 16'h1234);
		acc(1'b1, 2'b01, 15'h0003, 16'hFFFF);
		acc(1'b0, 2'b00, 15'h0003, DATA_ZERO);
		check(q, 16'hA5FF);
		acc(1'b0, 2'b00, 15'h0004, DATA_ZERO);
		check(q, 16'h1234);
	endtask
	task automatic test_fixed(input logic [1:0] d);
		restart(1'b1, d);
		acc(1'b1, 2'b11, 15'h0007, 16'h5A0F ^ {14'h0, d});
		acc(1'b0, 2'b00, 15'h0007, DATA_ZERO);
		check(q, 16'h5A0F ^ {14'h0, d});
		check(blit, 1'b0);
	endtask
	task automatic test_refused();
		blitTgt <= 1'b1;
		acc(1'b1, 2'b11, 15'h0007, 16'hFFFF);
		acc(1'b0, 2'b00, 15'h0007, DATA_ZERO);
		check(q, DATA_ZERO);
		blitTgt <= 1'b0;
		acc(1'b0, 2'b00, 15'h0007, DATA_ZERO);
		check(q, 16'h5A0E);
	endtask
	initial begin
		test_ack();
		test_fixed(2'h0);
		test_fixed(2'h1);
		test_refused();
		conclude();
	end
	initial begin
		#100000;
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
